// *** pkg/sap_pkg.sv ***
// Package of constants and types for the sampling converter port logic
package sap_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_PERIOD_PS       = 4000;
	localparam int START_PULSE_NS      = 1000;
	localparam int START_PULSE_CYC     = (START_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int POWER_UP_NS         = 1000;
	localparam int POWER_UP_CYC_RAW    = (POWER_UP_NS * 1000) / CLK_PERIOD_PS;
	localparam int POWER_UP_CYC        = (POWER_UP_CYC_RAW < 1) ? 1 : POWER_UP_CYC_RAW;
	localparam int CONV_TIME_NS        = 4500;
	localparam int CONV_CYC_RAW        = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int CONV_CYC            = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
	localparam int CNT_W               = 11;

	// ==========================================================
	// Data width, reset value and sequencer states
	localparam int RESULT_W            = 8;
	localparam logic [7:0] RESULT_RST  = 8'h00;

	typedef enum logic [1:0] {
		SAP_POWERED_DOWN,
		SAP_IDLE,
		SAP_CONVERT
	} sap_state_type;

endpackage

// *** tb/sap_core_properties.sv ***
// Port assertions of the converter control logic
`timescale 1ns/1ps
module sap_chk
(
	input wire logic       CORE_CLK,
	input wire logic       RSTN,
	input wire logic       CONVERSION_START_N,
	input wire logic       SELECT_N,
	input wire logic       READ_N,
	input wire logic       BUSY,
	input wire logic       POWERED,
	input wire logic [7:0] RESULT_BUS_O,
	input wire logic [7:0] RESULT_BUS_OE_N
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	property p_go; $fell(CONVERSION_START_N) && POWERED && !BUSY |-> ##[1:251] BUSY; endproperty
	a_go: assert property (p_go) else $error("busy late");
	property p_len; $rose(BUSY) |-> BUSY[*8]; endproperty
	a_len: assert property (p_len) else $error("busy short");
	property p_drv; !SELECT_N && !READ_N |=> RESULT_BUS_OE_N == 8'h00; endproperty
	a_drv: assert property (p_drv) else $error("bus not driven");
	property p_rel; SELECT_N || READ_N |=> RESULT_BUS_OE_N == 8'hFF; endproperty
	a_rel: assert property (p_rel) else $error("bus not released");
	property p_hld; $changed(RESULT_BUS_O) |-> !BUSY; endproperty
	a_hld: assert property (p_hld) else $error("result moved");
	property p_pdl; $fell(BUSY) && !$past(CONVERSION_START_N) |-> ##[0:1] !POWERED; endproperty
	a_pdl: assert property (p_pdl) else $error("no power down");
	property p_pdh; $fell(BUSY) && $past(CONVERSION_START_N) |-> POWERED; endproperty
	a_pdh: assert property (p_pdh) else $error("powered down");
	property p_up; $rose(CONVERSION_START_N) && !POWERED |-> ##[1:251] POWERED; endproperty
	a_up: assert property (p_up) else $error("power up late");
	c_conv: cover property ($fell(BUSY));
	c_read: cover property (!SELECT_N && !READ_N);
	c_wake: cover property ($rose(POWERED));
endmodule
bind sap_core sap_chk chk_i (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
	.CONVERSION_START_N(CONVERSION_START_N), .SELECT_N(SELECT_N), .READ_N(READ_N),
	.BUSY(BUSY), .POWERED(POWERED), .RESULT_BUS_O(RESULT_BUS_O),
	.RESULT_BUS_OE_N(RESULT_BUS_OE_N));

// *** tb/sap_core_test.sv ***
// Self-checking bench of the converter control logic
`timescale 1ns/1ps
module sap_core_test;
	logic       clk = 1'h0, rstn = 1'h0;
	logic [7:0] smp = 8'hA5, o, oe_n, d;
	logic       busy, pwr, st_n, cs_n, rd_n;
	// Released bus shows inverted data, never a stale copy
	wire  [7:0] bus = oe_n[0] ? ~o : o;
	int         miscompares = 0, num_checks = 0;
	always #2 clk = ~clk;
	sap_core #(.CONV_CYCLES(20)) uut (.CORE_CLK(clk), .RSTN(rstn), .CONVERSION_START_N(st_n),
		.SELECT_N(cs_n), .READ_N(rd_n), .SAMPLE_IN(smp), .BUSY(busy), .POWERED(pwr),
		.RESULT_BUS_O(o), .RESULT_BUS_OE_N(oe_n));
	sap_host host (.clk(clk), .bus(bus), .st_n(st_n), .cs_n(cs_n), .rd_n(rd_n));
	task automatic chk(input string n, input logic [7:0] e, s);
		num_checks++;
		miscompares += int'(s !== e);
		if (s !== e)
			$display("[ERR] %s exp %h got %h", n, e, s);
	endtask
	task automatic report_and_stop();
		if (miscompares == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic t_slow();
		host.go(1'h0, 0);
		repeat (20) @(posedge clk);
		chk("pwr", 0, pwr);
		host.go(1'h1, 0);
		host.go(1'h0, 8);
		repeat (200) @(posedge clk);
		chk("busy", 0, busy);
		@(negedge busy);
		repeat (2) @(posedge clk);
		chk("pd", 0, pwr);
		host.rd(d);
		chk("rd", 8'hA5, d);
		repeat (2) @(posedge clk);
		chk("rel", 8'hFF, oe_n);
	endtask
	task automatic t_fast();
		host.go(1'h1, 0);
		repeat (251) @(posedge clk);
		chk("up", 1, pwr);
		smp <= 8'h5A;
		host.go(1'h0, 25);
		repeat (2) @(posedge clk);
		chk("busy", 1, busy);
		host.go(1'h1, 0);
		host.rd(d);
		chk("old", 8'hA5, d);
		@(negedge busy);
		repeat (2) @(posedge clk);
		chk("pwr", 1, pwr);
		host.rd(d);
		chk("new", 8'h5A, d);
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		t_slow();
		t_fast();
		report_and_stop();
	end
	initial
	begin
		#20000 miscompares++;
		report_and_stop();
	end
endmodule

// *** tb/sap_host.sv ***
// Host model driving start and read strobes
`timescale 1ns/1ps
module sap_host
(
	input  wire logic       clk,
	input  wire logic [7:0] bus,
	output logic            st_n = 1'h1,
	output logic            cs_n = 1'h1,
	output logic            rd_n = 1'h1
);
	task automatic go(input logic v, input int gap);
		// Quiet time after release and conversion before a new fall
		repeat (gap) @(posedge clk);
		st_n <= v;
		@(posedge clk);
	endtask
	task automatic rd(output logic [7:0] d);
		{cs_n, rd_n} <= 2'h0;
		repeat (2) @(posedge clk);
		d = bus;
		{cs_n, rd_n} <= 2'h3;
	endtask
endmodule

// *** verilog/sap_core.sv ***
// Conversion sequencing and parallel read port of the sampling converter
`timescale 1ns/1ps
module sap_core
	import sap_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYC,
	parameter int DATA_W      = RESULT_W
)
(
	input  wire logic              CORE_CLK,
	input  wire logic              RSTN,
	input  wire logic              CONVERSION_START_N,
	input  wire logic              SELECT_N,
	input  wire logic              READ_N,
	input  wire logic [DATA_W-1:0] SAMPLE_IN,
	output logic                   BUSY,
	output logic                   POWERED,
	output logic      [DATA_W-1:0] RESULT_BUS_O,
	output logic      [DATA_W-1:0] RESULT_BUS_OE_N
);
	// ==========================================================
	// Edge detection of the start input
	logic start_q;
	logic start_rise;
	logic start_fall;

	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
			start_q <= 1'b1;
		else
			start_q <= CONVERSION_START_N;
	end

	assign start_rise = CONVERSION_START_N & ~start_q;
	assign start_fall = ~CONVERSION_START_N & start_q;

	// ==========================================================
	// Internal start pulse and power-up timers
	logic pulse_active;
	logic pwrup_active;

	sap_pulse_timer #(.LEN(START_PULSE_CYC)) u_start_pulse
	(
		.clk     (CORE_CLK),
		.rst_n   (RSTN),
		.trigger (start_rise),
		.active  (pulse_active)
	);

	// POWERED is registered one edge after the timer ends, so the timer runs one cycle short
	sap_pulse_timer #(.LEN(POWER_UP_CYC - 1)) u_power_up
	(
		.clk     (CORE_CLK),
		.rst_n   (RSTN),
		.trigger (start_rise),
		.active  (pwrup_active)
	);

	// ==========================================================
	// Sequencer
	sap_state_type    state_q;
	sap_state_type    state_d;
	logic [CNT_W-1:0] conv_cnt_q;
	logic [CNT_W-1:0] conv_cnt_d;
	logic             pending_q;
	logic             pending_d;
	logic             busy_q;
	logic             busy_d;
	logic             powered_q;
	logic             powered_d;
	logic [DATA_W-1:0] result_q;
	logic [DATA_W-1:0] result_d;
	logic             go;

	// Pending start waits out the internal pulse instead of being lost
	assign go = (start_fall | pending_q) & ~pulse_active;

	always_comb
	begin
		state_d    = state_q;
		conv_cnt_d = conv_cnt_q;
		pending_d  = pending_q;
		busy_d     = busy_q;
		powered_d  = powered_q;
		result_d   = result_q;
		case (state_q)
			SAP_POWERED_DOWN:
			begin
				powered_d = 1'b0;
				if (start_rise)
				begin
					// Power comes up only when the power-up timer runs out
					state_d   = SAP_IDLE;
				end
			end
			SAP_IDLE:
			begin
				powered_d = ~pwrup_active | powered_q;
				if (start_fall && pulse_active)
					pending_d = 1'b1;
				if (go)
				begin
					pending_d  = 1'b0;
					busy_d     = 1'b1;
					conv_cnt_d = CNT_W'(CONV_CYCLES);
					state_d    = SAP_CONVERT;
				end
			end
			SAP_CONVERT:
			begin
				conv_cnt_d = conv_cnt_q - 1'b1;
				if (conv_cnt_q == CNT_W'(1))
				begin
					busy_d   = 1'b0;
					result_d = SAMPLE_IN;
					// Low start level at the end selects automatic power-down
					if (!CONVERSION_START_N)
						state_d = SAP_POWERED_DOWN;
					else
						state_d = SAP_IDLE;
				end
			end
			default:
			begin
				state_d = SAP_POWERED_DOWN;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
		begin
			state_q    <= SAP_POWERED_DOWN;
			conv_cnt_q <= '0;
			pending_q  <= 1'b0;
			busy_q     <= 1'b0;
			powered_q  <= 1'b0;
			result_q   <= DATA_W'(RESULT_RST);
		end
		else
		begin
			state_q    <= state_d;
			conv_cnt_q <= conv_cnt_d;
			pending_q  <= pending_d;
			busy_q     <= busy_d;
			powered_q  <= powered_d;
			result_q   <= result_d;
		end
	end

	// ==========================================================
	// Read port; one cycle of access latency, enables are active low
	logic [DATA_W-1:0] bus_o_q;
	logic [DATA_W-1:0] bus_o_d;
	logic [DATA_W-1:0] bus_oe_n_q;
	logic [DATA_W-1:0] bus_oe_n_d;

	always_comb
	begin
		bus_o_d    = result_q;
		bus_oe_n_d = {DATA_W{~(~SELECT_N & ~READ_N)}};
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RSTN)
		begin
			bus_o_q    <= DATA_W'(RESULT_RST);
			bus_oe_n_q <= '1;
		end
		else
		begin
			bus_o_q    <= bus_o_d;
			bus_oe_n_q <= bus_oe_n_d;
		end
	end

	assign BUSY            = busy_q;
	assign POWERED         = powered_q;
	assign RESULT_BUS_O    = bus_o_q;
	assign RESULT_BUS_OE_N = bus_oe_n_q;
endmodule

// *** verilog/sap_pulse_timer.sv ***
// Retriggerable one-shot timer used for start pulse and power-up
`timescale 1ns/1ps
module sap_pulse_timer
	import sap_pkg::*;
#(
	parameter int LEN = 1
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic trigger,
	output logic      active
);
	// ==========================================================
	// Counter
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	always_comb
	begin
		cnt_d = cnt_q;
		if (trigger)
			cnt_d = CNT_W'(LEN);
		else if (cnt_q != '0)
			cnt_d = cnt_q - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

	assign active = (cnt_q != '0);
endmodule
